/* File: tb/core_model.sv */
// Purpose: Core stand-in issuing watchdog clear and sleep pulses
// Assumes: Bench asks for sleep or clear with one-cycle strobes
// Notes: Every sleep comes one cycle after a watchdog clear, except one asked for while instr_sleep is high
`timescale 1ns/1ps
`default_nettype none
module core_model
    import sleep_wake_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic go_sleep,
    input wire logic go_clear,
    input wire logic [PC_WIDTH-1:0] sleep_pc,
    output logic instr_sleep,
    output logic instr_watchdog_clear,
    output logic [PC_WIDTH-1:0] pc
);
    logic armed;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            armed <= 1'b0;
            instr_sleep <= 1'b0;
            instr_watchdog_clear <= 1'b0;
            pc <= '0;
        end
        else
        begin
            armed <= go_sleep;
            instr_watchdog_clear <= (go_sleep | go_clear)
                && !instr_sleep;
            instr_sleep <= armed;
            pc <= sleep_pc;
        end
    end
endmodule : core_model
`default_nettype wire

/* File: tb/test_sleep_wake_watchdog_ctrl.sv */
// Purpose: Self-checking bench for sleep, wake and watchdog control
// Assumes: Short watchdog base count of 8 cycles
// Notes: Random program counters and sources from a fixed LFSR
`timescale 1ns/1ps
`default_nettype none
module test_sleep_wake_watchdog_ctrl;
    import sleep_wake_pkg::*;
    localparam int BASE = 8;
    logic mclk, reset, ce, go_sleep, go_clear, master_clear_n;
    logic global_interrupt_enable;
    reg_req_t bus_req;
    logic [7:0] config_byte, reg_rdata, flags, enables, clockless;
    logic [PC_WIDTH-1:0] sleep_pc, pc, prefetch_addr;
    logic instr_sleep, instr_watchdog_clear, osc_enable, port_hold;
    logic device_reset_req, prefetch_valid, resume_pulse;
    logic vector_request, power_down_flag, time_out_flag;
    logic [15:0] lfsr;
    int miscompares, checked;

    sleep_wake_watchdog_ctrl #(.NUM_SRC(8), .WDT_BASE_CYCLES(BASE)) dut (
        .mclk(mclk), .reset(reset), .ce(ce), .bus_req(bus_req),
        .reg_rdata(reg_rdata), .config_byte(config_byte),
        .instr_sleep(instr_sleep),
        .instr_watchdog_clear(instr_watchdog_clear), .pc(pc),
        .global_interrupt_enable(global_interrupt_enable),
        .int_flags(flags),
        .int_enables(enables), .clockless_src(clockless),
        .master_clear_n(master_clear_n), .osc_enable(osc_enable),
        .port_hold(port_hold), .device_reset_req(device_reset_req),
        .prefetch_addr(prefetch_addr), .prefetch_valid(prefetch_valid),
        .resume_pulse(resume_pulse), .vector_request(vector_request),
        .power_down_flag(power_down_flag), .time_out_flag(time_out_flag));

    core_model core (.mclk(mclk), .reset(reset), .go_sleep(go_sleep),
        .go_clear(go_clear), .sleep_pc(sleep_pc), .instr_sleep(instr_sleep),
        .instr_watchdog_clear(instr_watchdog_clear), .pc(pc));

    function automatic logic [15:0] lfsr_step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_step

    function automatic logic [PC_WIDTH-1:0] fetch_after(
        input logic [PC_WIDTH-1:0] p);
        return p + 21'h000002;
    endfunction : fetch_after

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic do_reset(input logic [7:0] cfg);
        @(posedge mclk);
        reset <= 1'b1;
        config_byte <= cfg;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
    endtask : do_reset

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge mclk);
        bus_req.write <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input string what, input logic [3:0] a,
        input logic [7:0] exp);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
        @(posedge mclk);
        bus_req.read <= 1'b0;
        @(negedge mclk);
        chk(what, {24'h0, exp}, {24'h0, reg_rdata});
    endtask : reg_check

    task automatic ask_sleep(input logic [PC_WIDTH-1:0] p);
        @(posedge mclk);
        sleep_pc <= p;
        go_sleep <= 1'b1;
        @(posedge mclk);
        go_sleep <= 1'b0;
    endtask : ask_sleep

    // Mode 0 late interrupt, 1 interrupt during entry, 2 watchdog
    task automatic nap(input int mode, input logic g, input logic [2:0] s);
        logic [PC_WIDTH-1:0] p;
        int n;
        p = {lfsr[4:0], lfsr} & 21'h1ffffe;
        lfsr = lfsr_step(lfsr);
        global_interrupt_enable <= g;
        enables <= 8'h01 << s | 8'h01 << (s + 3'd1);
        clockless <= 8'h01 << s | 8'h01 << (s + 3'd2);
        ask_sleep(p);
        repeat (2) @(posedge mclk);
        if (mode == 1)
            flags <= 8'h01 << s;
        if (mode == 0)
        begin
            repeat (8) @(negedge mclk);
            chk("osc off", 0, osc_enable);
            chk("port hold", 1, port_hold);
            chk("power down", 0, power_down_flag);
            chk("time out", 1, time_out_flag);
            chk("prefetch", fetch_after(p), prefetch_addr);
            chk("prefetch ok", 1, prefetch_valid);
            @(posedge mclk);
            flags <= 8'h01 << (s + 3'd1) | 8'h01 << (s + 3'd2);
            repeat (10) @(negedge mclk);
            chk("no wake", 0, osc_enable);
            @(posedge mclk);
            flags <= 8'h01 << s;
        end
        n = 0;
        while (resume_pulse !== 1'b1 && n < 60)
        begin
            @(negedge mclk);
            n++;
        end
        chk("resumed", 1, resume_pulse);
        chk("vector", g, vector_request);
        chk("osc back", 1, osc_enable);
        chk("port free", 0, port_hold);
        chk("prefetch kept", 1, prefetch_valid);
        chk("power down at wake", 0, power_down_flag);
        chk("time out at wake", mode != 2, time_out_flag);
        chk("no reset", 0, device_reset_req);
        @(posedge mclk);
        flags <= 8'h00;
    endtask : nap

    task automatic dog(input logic [7:0] cfg, input logic sw,
        input logic fires);
        int n;
        do_reset(cfg);
        reg_check("config", WDCFG_OFFSET, cfg & 8'h0f);
        reg_check("status", STATUS_OFFSET, {4'h0, cfg[0], 3'b010});
        reg_write(WDSW_OFFSET, {7'h00, sw});
        repeat (12)
        begin
            @(posedge mclk);
            go_clear <= 1'b1;
            @(posedge mclk);
            go_clear <= 1'b0;
            repeat (6) @(negedge mclk);
            chk("cleared dog", 0, device_reset_req);
        end
        n = 0;
        while (device_reset_req !== 1'b1 && n < 60)
        begin
            @(negedge mclk);
            n++;
        end
        chk("dog fires", fires, n < 60);
        if (fires)
            chk("dog period", 1, n >= 12 && n <= 24);
    endtask : dog

    initial
    begin
        mclk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    end

    initial
    begin
        #800000;
        miscompares++;
        end_of_test();
    end

    initial
    begin
        reset = 1'b1;
        ce = 1'b1;
        config_byte = 8'h02;
        bus_req = '0;
        go_sleep = 1'b0;
        go_clear = 1'b0;
        sleep_pc = '0;
        master_clear_n = 1'b1;
        global_interrupt_enable = 1'b0;
        flags = 8'h00;
        enables = 8'h00;
        clockless = 8'h00;
        lfsr = 16'h431d;
        miscompares = 0;
        checked = 0;
        do_reset(8'h02);
        reg_check("cause", RCAUSE_OFFSET, 8'h18);
        reg_write(WDSW_OFFSET, 8'hfe);
        reg_check("sw ctl", WDSW_OFFSET, 8'h00);
        @(posedge mclk);
        ce <= 1'b0;
        reg_write(WDSW_OFFSET, 8'h03);
        ce <= 1'b1;
        reg_check("ce hold", WDSW_OFFSET, 8'h00);
        reg_write(RCAUSE_OFFSET, 8'h80);
        reg_check("cause prio", RCAUSE_OFFSET, 8'h98);
        reg_check("unmapped", 4'h9, 8'h00);
        @(posedge mclk);
        enables <= 8'h10;
        flags <= 8'h10;
        ask_sleep(21'h000100);
        repeat (8) @(negedge mclk);
        chk("noop osc", 1, osc_enable);
        chk("noop power down", 1, power_down_flag);
        chk("noop time out", 1, time_out_flag);
        reg_check("noop cause", RCAUSE_OFFSET, 8'h98);
        @(posedge mclk);
        flags <= 8'h00;
        for (int i = 0; i < 6; i++)
        begin
            nap(i % 2, lfsr[7], lfsr[2:0]);
            lfsr = lfsr_step(lfsr);
        end
        reg_check("slept cause", RCAUSE_OFFSET, 8'h90);
        reg_write(WDSW_OFFSET, 8'h01);
        nap(2, 1'b0, 3'd0);
        do_reset(8'h02);
        ask_sleep(21'h000040);
        repeat (8) @(posedge mclk);
        master_clear_n <= 1'b0;
        repeat (4) @(negedge mclk);
        chk("pin reset", 1, device_reset_req);
        chk("pin no resume", 0, resume_pulse);
        @(posedge mclk);
        master_clear_n <= 1'b1;
        dog(8'h02, 1'b1, 1'b1);
        dog(8'h02, 1'b0, 1'b0);
        dog(8'h03, 1'b0, 1'b1);
        end_of_test();
    end
endmodule : test_sleep_wake_watchdog_ctrl
`default_nettype wire

/* File: verilog/sleep_wake_pkg.sv */
// Purpose: Shared constants and types for the sleep, wake and watchdog block
// Assumes: 8-bit register port, one clock at 25 MHz
// Notes: Register offsets sit on a small private index space
package sleep_wake_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 40;

    // Register offsets
    localparam logic [3:0] WDSW_OFFSET = 4'h0;
    localparam logic [3:0] WDCFG_OFFSET = 4'h1;
    localparam logic [3:0] RCAUSE_OFFSET = 4'h2;
    localparam logic [3:0] STATUS_OFFSET = 4'h3;

    // Software control fields
    localparam int SW_ENABLE_BIT = 0;
    localparam logic [7:0] WDSW_RESET = 8'h00;

    // Configuration byte fields
    localparam int CFG_ENABLE_BIT = 0;
    localparam int CFG_PS_LSB = 1;
    localparam int CFG_PS_MSB = 3;
    localparam logic [7:0] CFG_USED_MASK = 8'h0f;

    // Reset-cause fields
    localparam int PRIO_ENABLE_BIT = 7;
    localparam int TIME_OUT_BIT = 4;
    localparam int POWER_DOWN_BIT = 3;
    localparam logic RCAUSE_FLAG_RESET = 1'b1;

    // Status fields
    localparam int STAT_ASLEEP_BIT = 0;
    localparam int STAT_OSC_BIT = 1;
    localparam int STAT_PENDING_BIT = 2;
    localparam int STAT_WDT_RUN_BIT = 3;

    // Watchdog base period in mclk cycles
    localparam int WDT_BASE_CYCLES_DEFAULT = 1024;
    localparam int PC_WIDTH = 21;
    localparam logic [20:0] PREFETCH_STEP = 21'h000002;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } reg_req_t;

    typedef struct packed {
        logic pending;
        logic wake;
    } wake_sum_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b100
    } power_state_t;

endpackage : sleep_wake_pkg

/* File: verilog/sleep_wake_watchdog_ctrl.sv */
// Purpose: Sleep entry, wake-up and watchdog control beside the core
// Assumes: Instruction strobes are one-cycle pulses from the core
// Notes: The block itself stays clocked; osc_enable gates the core clock
//
// Functional notes
// R1 - Software enable 1 runs watchdog; 0 stops it only if config enable 0.
// R2 - Upper seven bits of software control register read as zero.
// R3 - Postscaler extends watchdog period; ratio set by configuration byte.
// R4 - Sleep clears watchdog, clears power-down, sets time-out, stops oscillator.
// R5 - I/O ports hold their drive state while asleep.
// R6 - Wake on master clear, watchdog, external pin, port change, peripherals.
// R7 - Only sources running without main clock can wake the device.
// R8 - Master clear gives full reset; other wake events continue execution.
// R9 - Power-down set at power-up, cleared by sleep; watchdog wake clears time-out.
// R10 - Sleep prefetches instruction at program counter plus two.
// R11 - Wake needs source enable set, regardless of global interrupt enable.
// R12 - Wake resumes after sleep; with global enable, then vectors.
// R13 - Already pending interrupt makes sleep a no-op, nothing cleared or set; the no-op still loads prefetch_addr and sets prefetch_valid.
// R14 - Interrupt arising during sleep: sleep completes, then immediate wake.
// R15 - Software tests power-down flag to see whether sleep happened.
// R16 - Software places a no-op after sleep if needed.
// R17 - Software clears watchdog before sleep.
// R18 - Watchdog timeout resets when running, wakes when asleep.
// R19 - Config enable set forces watchdog on, software cannot stop it.
// R20 - Clear and sleep instructions reset watchdog and postscaler counts.
// R21 - Non-reset wake restarts oscillator and keeps prefetch valid.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_watchdog_ctrl
    import sleep_wake_pkg::*;
#(
    parameter int NUM_SRC = 8,
    parameter int WDT_BASE_CYCLES = WDT_BASE_CYCLES_DEFAULT
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire reg_req_t bus_req,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] config_byte,
    input wire logic instr_sleep,
    input wire logic instr_watchdog_clear,
    input wire logic [PC_WIDTH-1:0] pc,
    input wire logic global_interrupt_enable,
    input wire logic [NUM_SRC-1:0] int_flags,
    input wire logic [NUM_SRC-1:0] int_enables,
    input wire logic [NUM_SRC-1:0] clockless_src,
    input wire logic master_clear_n,
    output logic osc_enable,
    output logic port_hold,
    output logic device_reset_req,
    output logic [PC_WIDTH-1:0] prefetch_addr,
    output logic prefetch_valid,
    output logic resume_pulse,
    output logic vector_request,
    output logic power_down_flag,
    output logic time_out_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    power_state_t state;
    power_state_t next_state;
    wake_sum_t summary;
    logic software_watchdog_enable;
    logic [7:0] watchdog_config_high;
    logic interrupt_priority_enable;
    logic wdt_timeout;

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    function automatic logic hit(input reg_req_t req, input logic [3:0] off);
        hit = req.addr == off;
    endfunction : hit

    wire wr_wdsw = ce && bus_req.write && hit(bus_req, WDSW_OFFSET);
    wire wr_rcause = ce && bus_req.write && hit(bus_req, RCAUSE_OFFSET);

    wire watchdog_config_enable = watchdog_config_high[CFG_ENABLE_BIT];
    wire [2:0] ps_select = watchdog_config_high[CFG_PS_MSB:CFG_PS_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Wake qualification

    wake_detect #(
        .NUM_SRC(NUM_SRC)
    ) u_wake (
        .int_flags(int_flags),
        .int_enables(int_enables),
        .clockless_src(clockless_src), // R7
        .summary(summary) // R11
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencing conditions

    wire in_run = state == ST_RUN;
    wire in_sleep = state == ST_SLEEP;
    wire in_wake = state == ST_WAKE;
    wire master_clear_active = !master_clear_n;
    wire sleep_noop = in_run && instr_sleep && summary.pending; // R13
    wire sleep_enter = in_run && instr_sleep && !summary.pending
        && !master_clear_active; // R4
    wire wdt_run = watchdog_config_enable
        || software_watchdog_enable; // R1 R19
    wire wdt_clear = sleep_enter || (in_run && instr_watchdog_clear); // R20
    wire sleep_wake_event = in_sleep && !master_clear_active
        && (summary.wake || wdt_timeout); // R6 R14
    wire reset_event = master_clear_active
        || (in_run && wdt_timeout); // R8 R18

    ////////////////////////////////////////////////////////////////////////
    // Watchdog

    wdt_counter #(
        .BASE_CYCLES(WDT_BASE_CYCLES)
    ) u_wdt (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .run(wdt_run),
        .clear(wdt_clear),
        .ps_select(ps_select), // R3
        .timeout(wdt_timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // Power state machine

    always_comb
    begin
        next_state = state;
        case (state)
            ST_RUN:
            begin
                if (sleep_enter)
                    next_state = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                if (master_clear_active)
                    next_state = ST_RUN; // R8
                else if (summary.wake || wdt_timeout)
                    next_state = ST_WAKE;
            end
            ST_WAKE:
            begin
                next_state = ST_RUN;
            end
            default:
            begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            state <= ST_RUN;
        else if (ce)
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock, pin hold and reset request

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            osc_enable <= 1'b1;
            port_hold <= 1'b0;
            device_reset_req <= 1'b0;
        end
        else if (ce)
        begin
            osc_enable <= next_state != ST_SLEEP; // R4 R21
            port_hold <= next_state == ST_SLEEP; // R5
            device_reset_req <= reset_event; // R8 R18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prefetch and resume

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            prefetch_addr <= '0;
            prefetch_valid <= 1'b0;
            resume_pulse <= 1'b0;
            vector_request <= 1'b0;
        end
        else if (ce)
        begin
            resume_pulse <= in_wake; // R12
            vector_request <= in_wake && global_interrupt_enable; // R12
            if (in_run && instr_sleep)
            begin
                prefetch_addr <= pc + PREFETCH_STEP; // R10
                prefetch_valid <= 1'b1;
            end
            else if (in_sleep && master_clear_active)
                prefetch_valid <= 1'b0;
            else if (resume_pulse || sleep_noop)
                prefetch_valid <= 1'b0; // R21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            power_down_flag <= RCAUSE_FLAG_RESET; // R9
            time_out_flag <= RCAUSE_FLAG_RESET;
        end
        else if (ce)
        begin
            if (sleep_enter)
                power_down_flag <= 1'b0; // R4 R9
            if (sleep_enter)
                time_out_flag <= 1'b1; // R4 R14
            else if (in_sleep && wdt_timeout)
                time_out_flag <= 1'b0; // R9
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            software_watchdog_enable <= WDSW_RESET[SW_ENABLE_BIT];
            interrupt_priority_enable <= 1'b0;
            watchdog_config_high <= config_byte & CFG_USED_MASK; // R3
        end
        else if (ce)
        begin
            if (wr_wdsw)
                software_watchdog_enable <= bus_req.wdata[SW_ENABLE_BIT];
            if (wr_rcause)
                interrupt_priority_enable <=
                    bus_req.wdata[PRIO_ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    logic [7:0] read_mux;

    always_comb
    begin
        read_mux = 8'h00;
        case (bus_req.addr)
            WDSW_OFFSET:
                read_mux[SW_ENABLE_BIT] = software_watchdog_enable; // R2
            WDCFG_OFFSET:
                read_mux = watchdog_config_high;
            RCAUSE_OFFSET:
            begin
                read_mux[PRIO_ENABLE_BIT] = interrupt_priority_enable;
                read_mux[TIME_OUT_BIT] = time_out_flag;
                read_mux[POWER_DOWN_BIT] = power_down_flag;
            end
            STATUS_OFFSET:
            begin
                read_mux[STAT_ASLEEP_BIT] = in_sleep;
                read_mux[STAT_OSC_BIT] = osc_enable;
                read_mux[STAT_PENDING_BIT] = summary.pending;
                read_mux[STAT_WDT_RUN_BIT] = wdt_run;
            end
            default:
                read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (ce)
            reg_rdata <= bus_req.read ? read_mux : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    wdt_forced_on_a: assert property ( // R19
        ce && watchdog_config_enable && !wdt_clear
        |=> u_wdt.base_count != $past(u_wdt.base_count))
        else $error("watchdog stalled with config enable set");

    sw_read_zero_a: assert property ( // R2
        ce && bus_req.read && bus_req.addr == WDSW_OFFSET
        |=> reg_rdata[7:1] == 7'h00
            && reg_rdata[0] == $past(software_watchdog_enable))
        else $error("software control read wrong");

    sleep_flags_a: assert property ( // R4
        ce && sleep_enter
        |=> !power_down_flag && time_out_flag && !osc_enable)
        else $error("sleep entry did not update flags");

    sleep_noop_a: assert property ( // R13
        ce && sleep_noop
        |=> state == ST_RUN
            && power_down_flag == $past(power_down_flag)
            && time_out_flag == $past(time_out_flag))
        else $error("pending interrupt sleep not a no-op");

    asleep_hold_a: assert property ( // R5
        state == ST_SLEEP |-> port_hold && !osc_enable)
        else $error("ports or oscillator not held in sleep");

    wake_event_a: assert property ( // R6
        ce && sleep_wake_event
        |=> state == ST_WAKE ##1 osc_enable)
        else $error("wake event did not wake");

    pin_reset_a: assert property ( // R8
        ce && in_sleep && master_clear_active
        |=> device_reset_req && state == ST_RUN && !resume_pulse)
        else $error("master clear in sleep did not reset");

    prefetch_step_a: assert property ( // R10
        ce && sleep_enter
        |=> prefetch_valid && prefetch_addr == $past(pc) + PREFETCH_STEP)
        else $error("prefetch address wrong");

    resume_vector_a: assert property ( // R12
        ce && in_wake
        |=> resume_pulse
            && vector_request == $past(global_interrupt_enable))
        else $error("resume or vector wrong after wake");

    timeout_clear_a: assert property ( // R9
        ce && in_sleep && wdt_timeout && !master_clear_active
        |=> !time_out_flag)
        else $error("time-out flag not cleared by watchdog wake");

    run_timeout_a: assert property ( // R18
        ce && in_run && wdt_timeout |=> device_reset_req)
        else $error("watchdog timeout did not request reset");

endmodule : sleep_wake_watchdog_ctrl
`default_nettype wire

/* File: verilog/wake_detect.sv */
// Purpose: Qualifies interrupt sources as pending or as able to wake
// Assumes: Flags, enables and capability are levels from the sources
// Notes: Global enable is deliberately not an input here
`timescale 1ns/1ps
`default_nettype none
module wake_detect
    import sleep_wake_pkg::*;
#(
    parameter int NUM_SRC = 8
)
(
    input wire logic [NUM_SRC-1:0] int_flags,
    input wire logic [NUM_SRC-1:0] int_enables,
    input wire logic [NUM_SRC-1:0] clockless_src,
    output wake_sum_t summary
);

    logic [NUM_SRC-1:0] enabled;
    logic [NUM_SRC-1:0] waker;

    for (genvar i = 0; i < NUM_SRC; i++)
    begin : g_src
        assign enabled[i] = int_flags[i] && int_enables[i];
        assign waker[i] = enabled[i] && clockless_src[i];
    end

    assign summary.pending = |enabled;
    assign summary.wake = |waker;

endmodule : wake_detect
`default_nettype wire

/* File: verilog/wdt_counter.sv */
// Purpose: Watchdog base counter followed by a power-of-two postscaler
// Assumes: Runs from mclk, the block clock, counting only in cycles with ce high
// Notes: Clear restarts both counts but leaves the selection untouched
`timescale 1ns/1ps
`default_nettype none
module wdt_counter
    import sleep_wake_pkg::*;
#(
    parameter int BASE_CYCLES = WDT_BASE_CYCLES_DEFAULT
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic run,
    input wire logic clear,
    input wire logic [2:0] ps_select,
    output logic timeout
);

    localparam int BASE_W = $clog2(BASE_CYCLES + 1);
    localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(BASE_CYCLES - 1);

    logic [BASE_W-1:0] base_count;
    logic [7:0] post_count;

    wire base_done = base_count == BASE_LAST;
    wire [7:0] post_last = (8'h01 << ps_select) - 8'h01;
    wire post_done = post_count == post_last;

    always_ff @(posedge mclk)
    begin
        if (reset || (ce && (clear || !run)))
        begin
            base_count <= '0;
            post_count <= 8'h00;
            timeout <= 1'b0;
        end
        else if (ce)
        begin
            timeout <= base_done && post_done;
            base_count <= base_done ? '0 : base_count + 1'b1;
            if (base_done)
                post_count <= post_done ? 8'h00 : post_count + 8'h01;
        end
    end

endmodule : wdt_counter
`default_nettype wire
